// ### rtl/hcfg_chan_guard.sv
// Channel on/off, overcurrent shutdown with re-engagement, gate current boost.
// Assumes oc_detect and diag_read are one-cycle pulses on clk_sys.
`timescale 1ns/1ps
module hcfg_chan_guard (
  input wire logic clk_sys,
  input wire logic rst_n,
  hcfg_chan_if.guard ch
);
  import hcfg_pkg::*;

  typedef struct packed {
    logic on;
    logic shut;
    logic armed;
    logic boost;
    logic ctrl_prev;
    logic cmd_prev;
    logic [1:0] gate_charge_current;
  } hcfg_guard_t;

  hcfg_guard_t s_q, s_d;
  logic cmd_on;
  logic turnoff;
  logic switch_ev;

  always_comb begin
    s_d = s_q;
    cmd_on = ch.en_out & ch.ctrl;
    // Turn-off by pin or by SPI; an overcurrent cut does not count
    // Judged on the command, so a channel already cut by overcurrent still sees it
    turnoff = s_q.cmd_prev & ~cmd_on;
    switch_ev = ch.ctrl & ~s_q.ctrl_prev;
    s_d.ctrl_prev = ch.ctrl;
    s_d.cmd_prev = cmd_on;
    if (s_q.shut && ch.diag_read) begin
      s_d.armed = 1'b1;
    end
    if (s_q.shut && switch_ev && (!ch.reengage_policy || s_q.armed)) begin
      s_d.shut = 1'b0;
      s_d.armed = 1'b0;
    end
    if (turnoff) begin
      s_d.boost = 1'b0;
    end
    // Set wins over the clear in the same cycle
    if (ch.oc_detect && s_q.on) begin
      s_d.shut = 1'b1;
      s_d.boost = 1'b1;
    end
    s_d.on = cmd_on & ~s_d.shut;
    s_d.gate_charge_current = s_d.boost ? boosted(ch.gcc_sel, ch.boost_mode) : ch.gcc_sel;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ch.gate_on = s_q.on;
  assign ch.gcc_eff = s_q.gate_charge_current;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  boost_on_oc_a: assert property ((ch.oc_detect && s_q.on) |=>
    (ch.gcc_eff == boosted($past(ch.gcc_sel), $past(ch.boost_mode))) && !ch.gate_on)
    else $error("gate current not boosted after overcurrent");
  boost_clear_a: assert property ((turnoff && !ch.oc_detect) |=>
    (ch.gcc_eff == $past(ch.gcc_sel)))
    else $error("boost not cleared at turn-off");
  reengage_a: assert property ((s_q.shut && s_q.armed == 1'b0 && ch.reengage_policy &&
    !ch.diag_read) |=> s_q.shut)
    else $error("channel released without readout");
  oc_cover_c: cover property (ch.oc_detect && s_q.on ##[1:50] ch.gate_on);
endmodule

// ### rtl/hcfg_chan_if.sv
// Per-channel bundle between the frame block, the channel guard and the diag timer.
// Assumes all three sit on clk_sys.
`timescale 1ns/1ps
interface hcfg_chan_if;
  logic [1:0] gcc_sel;
  logic boost_mode;
  logic reengage_policy;
  logic en_out;
  logic ctrl;
  logic oc_detect;
  logic diag_read;
  logic [1:0] tdiag_code;
  logic gate_on;
  logic [1:0] gcc_eff;
  logic diag_ready;
  modport ctl (output gcc_sel, boost_mode, reengage_policy, en_out, ctrl, oc_detect,
    diag_read, tdiag_code, input gate_on, gcc_eff, diag_ready);
  modport guard (input gcc_sel, boost_mode, reengage_policy, en_out, ctrl, oc_detect,
    diag_read, output gate_on, gcc_eff);
  modport timer (input gate_on, tdiag_code, output diag_ready);
endinterface

// ### rtl/hcfg_diag_timer.sv
// Off-state diagnostic blanking/filter timer for one channel.
// Assumes the effective code is already chosen by the frame block.
`timescale 1ns/1ps
module hcfg_diag_timer #(
  parameter int CYC_0 = hcfg_pkg::TDIAG0_CYC,
  parameter int CYC_1 = hcfg_pkg::TDIAG1_CYC,
  parameter int CYC_2 = hcfg_pkg::TDIAG2_CYC,
  parameter int CYC_3 = hcfg_pkg::TDIAG3_CYC,
  parameter int TW = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  hcfg_chan_if.timer ch
);
  import hcfg_pkg::*;

  if (CYC_0 < 1 || CYC_1 < 1 || CYC_2 < 1 || CYC_3 < 1 ||
      CYC_3 >= (1 << TW) || CYC_2 >= (1 << TW)) begin : g_bad
    $error("diag timer counts out of range");
  end

  typedef struct packed {
    logic [TW-1:0] cnt;
    logic ready;
  } hcfg_timer_t;

  hcfg_timer_t s_q, s_d;
  logic [TW-1:0] limit;

  function automatic logic [TW-1:0] limit_of(input logic [1:0] code);
    case (code)
      2'h0: limit_of = TW'(CYC_0);
      2'h1: limit_of = TW'(CYC_1);
      2'h2: limit_of = TW'(CYC_2);
      default: limit_of = TW'(CYC_3);
    endcase
  endfunction

  always_comb begin
    s_d = s_q;
    limit = limit_of(ch.tdiag_code);
    if (ch.gate_on) begin
      s_d.cnt = '0;
      s_d.ready = 1'b0;
    end else if (s_q.cnt < limit) begin
      s_d.cnt = s_q.cnt + 1'b1;
      s_d.ready = (s_d.cnt >= limit);
    end else begin
      s_d.ready = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ch.diag_ready = s_q.ready;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  ready_time_a: assert property (ch.diag_ready |-> s_q.cnt >= $past(limit))
    else $error("diag ready before blanking elapsed");
  ready_cover_c: cover property ($rose(ch.diag_ready));
endmodule

// ### rtl/hcfg_frames.sv
// Configuration frames for outputs 3 and 4 with bridge 1 and peak-and-hold 1 settings.
// Assumes SPI pins already synchronous to clk_sys; host samples SDO at SCK rise.
//
// What this block does
// - Response carries command number 0011 or 0100.
// - Bit 27 zero writes, one reads only.
// - Bit 0 odd-count parity, checked and generated.
// - Bridge current limit uses channel 3, shunt only.
// - Freewheel select: passive low or active.
// - Overcurrent raises gate current one or two steps.
// - Boost cleared at next internal turn-off.
// - Off-state diag time by code, bridge overrides unless extended select set.
// - Readback bit picks fixed or actual threshold.
// - Six-bit overcurrent threshold, reset zero.
// - Temperature compensation code, zero disables.
// - Battery compensation on when bit set.
// - Three-bit overcurrent blanking code.
// - Re-engage on switching, optionally after readout.
// - Sense by drain-source or shunt.
// - Open-load regulator current 100 uA or 1 mA.
// - Gate current code selects four drive levels.
// - Low/high side and NMOS/PMOS selection.
// - Bridge 1 enable joins channels 1 to 4.
// - Peak-hold masking reports no-fail or not-done.
// - Peak-and-hold 1 enable for channels 1-4.
// - All fields reset on power-on or reset input.
`timescale 1ns/1ps
module hcfg_frames #(
  parameter int TDIAG_CYC_2 = hcfg_pkg::TDIAG2_CYC,
  parameter int TDIAG_CYC_3 = hcfg_pkg::TDIAG3_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic spi_csn,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_sdo,
  output logic spi_sdo_oe_n,
  output logic frame_fault,
  input wire logic ch3_ctrl,
  input wire logic ch4_ctrl,
  input wire logic ch3_oc_detect,
  input wire logic ch4_oc_detect,
  input wire logic ch3_diag_read,
  input wire logic ch4_diag_read,
  input wire logic ph1_open_load,
  input wire logic bridge1_extended_diag_timer_select,
  input wire logic [1:0] bridge1_tdiag_code,
  output logic [hcfg_pkg::RW_BIT:hcfg_pkg::CFG_LO] ch3_config,
  output logic [hcfg_pkg::RW_BIT:hcfg_pkg::CFG_LO] ch4_config,
  output logic bridge1_current_limit_enable,
  output logic bridge1_freewheel_select,
  output logic bridge1_enable,
  output logic peakhold1_enable,
  output logic [1:0] ph1_diag_code,
  output logic ch3_gate_on,
  output logic ch4_gate_on,
  output logic [1:0] ch3_gate_current,
  output logic [1:0] ch4_gate_current,
  output logic ch3_diag_ready,
  output logic ch4_diag_ready
);
  import hcfg_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic csn_prev;
    logic sck_prev;
    logic [CNT_W-1:0] cnt;
    logic [31:0] shift;
    logic sdo;
    logic sdo_oe_n;
    logic sel4;
    logic fault;
    logic [RW_BIT:CFG_LO] cfg3;
    logic [RW_BIT:CFG_LO] cfg4;
    logic ilim;
    logic afw;
    logic [1:0] ph1;
  } hcfg_state_t;

  hcfg_state_t s_q, s_d;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic [31:0] rx;
  logic good;
  logic [31:0] resp;
  logic bridge_timers;

  hcfg_chan_if c3 ();
  hcfg_chan_if c4 ();

  // ****************************************************************
  // Frame engine and register file
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    cs_fall = s_q.csn_prev & ~spi_csn;
    cs_rise = ~s_q.csn_prev & spi_csn;
    sck_rise = ~spi_csn & spi_sck & ~s_q.sck_prev;
    rx = s_q.shift;
    // Answer names the command that was last accepted
    resp = s_q.sel4 ? frame_word(CMD_OUT4, s_q.cfg4) : frame_word(CMD_OUT3, s_q.cfg3);
    good = (s_q.cnt == FRAME_LEN) && (rx[0] == parity_of(rx[31:1])) &&
      (rx[CMD_HI:CMD_LO] == CMD_OUT3 || rx[CMD_HI:CMD_LO] == CMD_OUT4);
    s_d.csn_prev = spi_csn;
    s_d.sck_prev = spi_sck;
    s_d.sdo_oe_n = spi_csn;
    if (cs_fall) begin
      s_d.shift = resp;
      s_d.sdo = resp[31];
      s_d.cnt = '0;
    end else if (sck_rise) begin
      s_d.shift = {s_q.shift[30:0], spi_mosi};
      s_d.sdo = s_q.shift[30];
      // Saturate past a full frame so long frames are refused
      if (s_q.cnt != FRAME_OVER) begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
    if (cs_rise) begin
      s_d.fault = ~good;
      if (good) begin
        s_d.sel4 = (rx[CMD_HI:CMD_LO] == CMD_OUT4);
        if (!rx[RW_BIT]) begin
          // Written frame reads back with its write flag clear
          if (rx[CMD_HI:CMD_LO] == CMD_OUT4) begin
            s_d.cfg4 = rx[RW_BIT:CFG_LO];
          end else begin
            s_d.cfg3 = rx[RW_BIT:CFG_LO];
          end
        end
      end
    end
    // Limiting is only meaningful with shunt sensing
    s_d.ilim = s_d.cfg3[F3_ILIM] & s_d.cfg3[SENSE];
    s_d.afw = s_d.cfg3[F3_AFW];
    if (s_d.cfg4[F4_PH]) begin
      s_d.ph1 = s_d.cfg4[F4_PH_POL] ? DIAG_NOT_DONE : DIAG_NO_FAIL;
    end else begin
      s_d.ph1 = ph1_open_load ? DIAG_OPEN_LOAD : DIAG_NO_FAIL;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.csn_prev <= 1'b1;
      s_q.sdo_oe_n <= 1'b1;
      s_q.cfg3 <= RST_OUT3[RW_BIT:CFG_LO];
      s_q.cfg4 <= RST_OUT4[RW_BIT:CFG_LO];
      s_q.afw <= RST_OUT3[F3_AFW];
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Channel guards and diagnostic timers
  // ****************************************************************
  // Bridge timers take over unless the extended select keeps the own code
  assign bridge_timers = s_q.cfg4[F4_BRIDGE] & ~bridge1_extended_diag_timer_select;

  assign c3.gcc_sel = s_q.cfg3[GCC_HI:GCC_LO];
  assign c3.boost_mode = s_q.cfg3[F3_BOOST];
  assign c3.reengage_policy = s_q.cfg3[REENG];
  assign c3.en_out = s_q.cfg3[EN_OUT];
  assign c3.ctrl = ch3_ctrl;
  assign c3.oc_detect = ch3_oc_detect;
  assign c3.diag_read = ch3_diag_read;
  assign c3.tdiag_code = bridge_timers ? bridge1_tdiag_code : s_q.cfg3[TDIAG_HI:TDIAG_LO];

  // The boost mode bit lives only in the output 3 frame and serves both
  assign c4.gcc_sel = s_q.cfg4[GCC_HI:GCC_LO];
  assign c4.boost_mode = s_q.cfg3[F3_BOOST];
  assign c4.reengage_policy = s_q.cfg4[REENG];
  assign c4.en_out = s_q.cfg4[EN_OUT];
  assign c4.ctrl = ch4_ctrl;
  assign c4.oc_detect = ch4_oc_detect;
  assign c4.diag_read = ch4_diag_read;
  assign c4.tdiag_code = bridge_timers ? bridge1_tdiag_code : s_q.cfg4[TDIAG_HI:TDIAG_LO];

  hcfg_chan_guard u_guard3 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ch(c3.guard)
  );

  hcfg_chan_guard u_guard4 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ch(c4.guard)
  );

  hcfg_diag_timer #(
    .CYC_2(TDIAG_CYC_2),
    .CYC_3(TDIAG_CYC_3)
  ) u_timer3 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ch(c3.timer)
  );

  hcfg_diag_timer #(
    .CYC_2(TDIAG_CYC_2),
    .CYC_3(TDIAG_CYC_3)
  ) u_timer4 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ch(c4.timer)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign spi_sdo = s_q.sdo;
  assign spi_sdo_oe_n = s_q.sdo_oe_n;
  assign frame_fault = s_q.fault;
  // Side, PMOS option, sense, open-load current and thresholds go out raw
  assign ch3_config = s_q.cfg3;
  assign ch4_config = s_q.cfg4;
  assign bridge1_current_limit_enable = s_q.ilim;
  assign bridge1_freewheel_select = s_q.afw;
  assign bridge1_enable = s_q.cfg4[F4_BRIDGE];
  assign peakhold1_enable = s_q.cfg4[F4_PH];
  assign ph1_diag_code = s_q.ph1;
  assign ch3_gate_on = c3.gate_on;
  assign ch4_gate_on = c4.gate_on;
  assign ch3_gate_current = c3.gcc_eff;
  assign ch4_gate_current = c4.gcc_eff;
  assign ch3_diag_ready = c3.diag_ready;
  assign ch4_diag_ready = c4.diag_ready;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  resp_cmd_a: assert property (cs_fall |=>
    (s_q.shift[CMD_HI:CMD_LO] == (s_q.sel4 ? CMD_OUT4 : CMD_OUT3)))
    else $error("response carries wrong command number");
  resp_parity_a: assert property (cs_fall |=>
    (s_q.shift[0] == parity_of(s_q.shift[31:1])))
    else $error("response parity wrong");
  bad_frame_a: assert property ((cs_rise && !good) |=>
    (frame_fault && $stable(s_q.cfg3) && $stable(s_q.cfg4)))
    else $error("bad frame changed configuration");
  read_only_a: assert property ((cs_rise && good && rx[RW_BIT]) |=>
    ($stable(s_q.cfg3) && $stable(s_q.cfg4) && !frame_fault))
    else $error("read-only frame changed configuration");
  write_take_a: assert property ((cs_rise && good && !rx[RW_BIT] &&
    rx[CMD_HI:CMD_LO] == CMD_OUT4) |=> (ch4_config == $past(rx[RW_BIT:CFG_LO])))
    else $error("write to output 4 frame lost");
  ilim_follow_a: assert property (bridge1_current_limit_enable ==
    (s_q.cfg3[F3_ILIM] && s_q.cfg3[SENSE]))
    else $error("current limit not gated by shunt sensing");
  ph1_mask_a: assert property (s_q.cfg4[F4_PH] |->
    (ph1_diag_code == (s_q.cfg4[F4_PH_POL] ? DIAG_NOT_DONE : DIAG_NO_FAIL)))
    else $error("peak-hold masking code wrong");
  sdo_idle_a: assert property (spi_csn |=> spi_sdo_oe_n)
    else $error("SDO driven while deselected");

  write_cover_c: cover property (cs_rise && good && !rx[RW_BIT]);
  fault_cover_c: cover property (cs_rise && !good);
  bridge_cover_c: cover property ($rose(bridge1_enable));
endmodule

// ### rtl/hcfg_pkg.sv
// Constants, field layout and helpers for the output 3/4 configuration frames.
// Assumes a 40 MHz system clock and 32-bit serial command words.
package hcfg_pkg;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int FRAME_BITS = 32;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] FRAME_LEN = 6'h20;
  localparam logic [CNT_W-1:0] FRAME_OVER = 6'h21;
  localparam logic [3:0] CMD_OUT3 = 4'h3;
  localparam logic [3:0] CMD_OUT4 = 4'h4;
  localparam int CMD_HI = 31;
  localparam int CMD_LO = 28;
  localparam int RW_BIT = 27;
  localparam int CFG_LO = 1;
  localparam int F3_ILIM = 26;
  localparam int F3_AFW = 25;
  localparam int F3_BOOST = 24;
  localparam int F4_BRIDGE = 26;
  localparam int F4_PH_POL = 25;
  localparam int F4_PH = 24;
  localparam int TDIAG_HI = 23;
  localparam int TDIAG_LO = 22;
  localparam int OCREAD = 21;
  localparam int OCTH_HI = 20;
  localparam int OCTH_LO = 15;
  localparam int TEMP_HI = 14;
  localparam int TEMP_LO = 13;
  localparam int BATT = 12;
  localparam int BLANK_HI = 11;
  localparam int BLANK_LO = 9;
  localparam int REENG = 8;
  localparam int SENSE = 7;
  localparam int OLCUR = 6;
  localparam int GCC_HI = 5;
  localparam int GCC_LO = 4;
  localparam int NP_BIT = 3;
  localparam int SIDE = 2;
  localparam int EN_OUT = 1;
  localparam logic [31:0] RST_OUT3 = 32'h3BC00000;
  localparam logic [31:0] RST_OUT4 = 32'h48C00001;

  // ****************************************************************
  // Gate current codes and diagnostic report codes
  // ****************************************************************
  localparam logic [1:0] GCC_20MA = 2'h1;
  localparam logic [1:0] GCC_5MA = 2'h2;
  localparam logic [1:0] GCC_1MA = 2'h3;
  typedef enum logic [1:0] {DIAG_NO_FAIL, DIAG_NOT_DONE, DIAG_OPEN_LOAD} hcfg_diag_t;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PS = 25000;
  localparam int TDIAG0_PS = 25600000;
  localparam int TDIAG1_PS = 61200000;
  localparam int TDIAG2_PS = 105600000;
  localparam int TDIAG3_PS = 150000000;
  // Blanking is a least time, so round up
  localparam int TDIAG0_CYC = (TDIAG0_PS + CLK_PS - 1) / CLK_PS;
  localparam int TDIAG1_CYC = (TDIAG1_PS + CLK_PS - 1) / CLK_PS;
  localparam int TDIAG2_CYC = (TDIAG2_PS + CLK_PS - 1) / CLK_PS;
  localparam int TDIAG3_CYC = (TDIAG3_PS + CLK_PS - 1) / CLK_PS;

  function automatic logic parity_of(input logic [30:0] b);
    parity_of = ~(^b);
  endfunction

  function automatic logic [31:0] frame_word(input logic [3:0] cmd, input logic [26:0] cfg);
    logic [30:0] hi;
    hi = {cmd, cfg};
    frame_word = {hi, parity_of(hi)};
  endfunction

  function automatic logic [1:0] boosted(input logic [1:0] sel, input logic mode);
    if (sel == GCC_1MA) begin
      boosted = mode ? GCC_20MA : GCC_5MA;
    end else if (sel == GCC_5MA) begin
      boosted = GCC_20MA;
    end else begin
      boosted = sel;
    end
  endfunction

endpackage

// ### test/hcfg_host_model.sv
// Host side of the serial link: frames 32-bit words MSB first and samples the answer.
// Assumes the device samples spi_sck and spi_mosi with clk_sys.
`timescale 1ns/1ps
module hcfg_host_model (
  input wire logic clk_sys,
  output logic spi_csn,
  output logic spi_sck,
  output logic spi_mosi,
  input wire logic spi_sdo
);
  initial begin
    spi_csn = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
  end

  // ****************************************************************
  // One frame; n other than 32 lets a test send a bad length
  // ****************************************************************
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    int i;
    rx = '0;
    @(posedge clk_sys);
    #1 spi_csn = 1'b0;
    for (i = 0; i < n; i++) begin
      // Sck low phase holds mosi steady; parity is the caller's job
      spi_mosi = (i < 32) ? tx[31-i] : 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 rx = {rx[30:0], spi_sdo};
      spi_sck = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 spi_sck = 1'b0;
    end
    repeat (2) @(posedge clk_sys);
    #1 spi_csn = 1'b1;
    // Idle data line must not look like the last bit
    spi_mosi = ~spi_mosi;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
endmodule

// ### test/tb_top.sv
// Self-checking bench for the output 3/4 configuration frames.
// Assumes hcfg_pkg is compiled first and a host model drives the serial pins.
`timescale 1ns/1ps
module tb_top;
  import hcfg_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic spi_csn, spi_sck, spi_mosi, spi_sdo, spi_sdo_oe_n, frame_fault;
  logic ctl3 = 1'b0, ctl4 = 1'b0, oc3 = 1'b0, oc4 = 1'b0, drd3 = 1'b0, drd4 = 1'b0;
  logic ph1_ol = 1'b0, ext_sel = 1'b0;
  logic [1:0] tcode = 2'h0;
  logic [27:1] ch3_config, ch4_config, m3, m4;
  logic lim, afw, br_en, ph_en, on3, on4, rdy3, rdy4;
  logic [1:0] ph_code, cur3, cur4;
  logic [3:0] sel;
  logic [31:0] w, md;
  int error_cnt = 0;
  int check_count = 0;
  int i, n;

  always #12.5 clk_sys = ~clk_sys;

  hcfg_host_model u_host (.clk_sys(clk_sys), .spi_csn(spi_csn), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .spi_sdo(spi_sdo));

  // Short diag counts keep the timer scenario inside the run budget
  hcfg_frames #(.TDIAG_CYC_2(20), .TDIAG_CYC_3(30)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .spi_csn(spi_csn), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_sdo(spi_sdo),
    .spi_sdo_oe_n(spi_sdo_oe_n), .frame_fault(frame_fault), .ch3_ctrl(ctl3),
    .ch4_ctrl(ctl4), .ch3_oc_detect(oc3), .ch4_oc_detect(oc4), .ch3_diag_read(drd3),
    .ch4_diag_read(drd4), .ph1_open_load(ph1_ol), .bridge1_extended_diag_timer_select(ext_sel),
    .bridge1_tdiag_code(tcode), .ch3_config(ch3_config), .ch4_config(ch4_config),
    .bridge1_current_limit_enable(lim), .bridge1_freewheel_select(afw),
    .bridge1_enable(br_en), .peakhold1_enable(ph_en), .ph1_diag_code(ph_code),
    .ch3_gate_on(on3), .ch4_gate_on(on4), .ch3_gate_current(cur3),
    .ch4_gate_current(cur4), .ch3_diag_ready(rdy3), .ch4_diag_ready(rdy4));

  // ****************************************************************
  // Reference model and helpers
  // ****************************************************************
  function automatic logic [31:0] fix(input logic [31:0] v);
    return {v[31:1], ~^v[31:1]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait2();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    m3 = 27'(32'h3BC00000 >> 1);
    m4 = 27'(32'h48C00001 >> 1);
    sel = 4'h3;
    wait2();
  endtask

  task automatic frame(input logic [31:0] v, input int len);
    logic [31:0] rx;
    logic ok;
    logic [1:0] pe;
    u_host.xfer(v, len, rx);
    if (len == 32) chk("resp", rx, fix({sel, (sel == 4'h3) ? m3 : m4, 1'b0}));
    ok = (len == 32) && (v[0] == ~^v[31:1]) && (v[31:28] == 4'h3 || v[31:28] == 4'h4);
    if (ok) begin
      sel = v[31:28];
      if (!v[27] && sel == 4'h3) m3 = v[27:1];
      if (!v[27] && sel == 4'h4) m4 = v[27:1];
    end
    chk("fault", frame_fault, !ok);
    chk("cfg3", ch3_config, m3);
    chk("cfg4", ch4_config, m4);
    chk("limit", lim, m3[26] & m3[7]);
    chk("afw", afw, m3[25]);
    chk("bridge", br_en, m4[26]);
    chk("peakhold", ph_en, m4[24]);
    pe = m4[24] ? (m4[25] ? DIAG_NOT_DONE : DIAG_NO_FAIL) : DIAG_NO_FAIL;
    if (!m4[24] && ph1_ol) pe = DIAG_OPEN_LOAD;
    chk("phdiag", ph_code, pe);
    chk("oe", spi_sdo_oe_n, 1'b1);
    chk("on4", on4, m4[1] & ctl4);
    chk("cur4", cur4, m4[5:4]);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(25 * 40000);
    error_cnt++;
    stop_test();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    void'($urandom(85052));
    do_reset();
    frame(fix(32'h38000000), 32);
    // Bad length both ways, bad parity, foreign command
    frame(fix(32'h3000000A), 31);
    frame(fix(32'h3000000A), 33);
    frame(fix(32'h3000000A) ^ 32'h1, 32);
    frame(fix(32'h5000000A), 32);
    for (i = 0; i < 10; i++) begin
      w = $urandom;
      w[31:28] = (i % 2) ? 4'h4 : 4'h3;
      ph1_ol = w[5];
      ext_sel = w[9];
      tcode = w[11:10];
      ctl4 = w[13];
      frame(fix(w), 32);
    end
    frame(fix(32'h38000000), 32);
    frame(fix(32'h48000000), 32);
    // Mid-run reset must restore both frames and the response choice
    do_reset();
    frame(fix(32'h48000000), 32);
    for (md = 0; md < 2; md++) begin
      frame(fix(32'h30C00032 | (md << 24) | (md << 8)), 32);
      ctl3 = 1'b1;
      wait2();
      chk("on", on3, 1'b1);
      chk("gcc", cur3, 2'h3);
      oc3 = 1'b1;
      @(posedge clk_sys);
      #1 oc3 = 1'b0;
      chk("shut", on3, 1'b0);
      chk("boost", cur3, md[0] ? 2'h1 : 2'h2);
      ctl3 = 1'b0;
      wait2();
      chk("unboost", cur3, 2'h3);
      ctl3 = 1'b1;
      wait2();
      chk("reengage", on3, !md[0]);
      if (md[0]) begin
        drd3 = 1'b1;
        @(posedge clk_sys);
        #1 drd3 = 1'b0;
        ctl3 = 1'b0;
        wait2();
        ctl3 = 1'b1;
        wait2();
        chk("readout", on3, 1'b1);
      end
      ctl3 = 1'b0;
      n = 0;
      while (rdy3 !== 1'b1 && n < 100) begin
        @(posedge clk_sys);
        #1 n++;
      end
      chk("tdiag", n >= 28 && n <= 33, 1'b1);
    end
    chk("rdy4", rdy4, 1'b1);
    stop_test();
  end
endmodule
